//--- tb/lcdd_glass_model.sv
`default_nettype none
module lcdd_glass_model (
    // Lines from the driver
    input  wire logic        clk_i,
    input  wire logic [40:0] fp_i,
    input  wire logic [40:0] fp_oe_i,
    input  wire logic [3:0]  bp_i,
    input  wire logic [3:0]  bp_oe_i,
    input  wire logic        ext_supply_req_i,
    // Panel view
    output logic      [5:0]  fp_driven_o,
    output logic             supply_ok_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [40:0] fp_line_q = '0;
    logic [3:0]  bp_line_q = '0;
    // Released lines float; invert the last level so a stale value is never trusted
    always @(posedge clk_i) begin
        fp_line_q <= (fp_oe_i & fp_i) | (~fp_oe_i & ~fp_line_q);
        bp_line_q <= (bp_oe_i & bp_i) | (~bp_oe_i & ~bp_line_q);
    end
    // Frontplanes the glass actually sees driven
    always_comb fp_driven_o = 6'($countones(fp_oe_i));
    // The system powers the supply pin only when the driver asks for it
    assign supply_ok_o = ext_supply_req_i;
endmodule // lcdd_glass_model
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic tick = 1'b0, tick_en = 1'b0, wait_m = 1'b0, stop_m = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat;
    logic ack, irq, pump, trip, buf_on, ext_exp, ext_ok, blank, bseg;
    logic [3:0]  sel = 4'h0, sel_n = 4'hF;
    logic [40:0] fp, fp_oe;
    logic [3:0]  bp, bp_oe;
    logic [5:0]  n_fp;
    logic [7:0]  exp_q[$];
    int miscompares = 0, n_tests = 0, seed = 32'heeca, k;
    logic [7:0] v;
    longint g_norm, g_lp, g_adj;

    lcdd_segment_ctrl lcdd_segment_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_ref_tick_i(tick), .wait_mode_i(wait_m),
        .deep_stop_mode_i(stop_m), .charge_pump_on_o(pump), .pump_tripler_o(trip),
        .high_drive_buffer_o(), .pump_clock_adjust_o(), .buffer_on_o(buf_on),
        .supply_source_select_o(), .ext_supply_expected_o(ext_exp), .fp_o(fp),
        .fp_oe_o(fp_oe), .bp_o(bp), .bp_oe_o(bp_oe), .blank_all_o(blank), .blink_segments_o(bseg),
        .lcd_irq_o(irq));
    lcdd_glass_model lcdd_glass_model_inst (.clk_i(clk_i), .fp_i(fp), .fp_oe_i(fp_oe),
        .bp_i(bp), .bp_oe_i(bp_oe), .ext_supply_req_i(ext_exp), .fp_driven_o(n_fp),
        .supply_ok_o(ext_ok));

    initial forever #50 clk_i = ~clk_i;
    // Random reference ticks, only while enabled
    always @(posedge clk_i) tick <= tick_en ? 1'($random(seed)) : 1'b0;

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle, held until ack, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= sel_n;
        adr <= a;
        dat <= {24'h0, d};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (i >= 20) begin
            miscompares++;
            final_report();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic wait_irq(input int lim);
        int i;
        i = 0;
        while (irq !== 1'b1 && i < lim) begin
            @(posedge clk_i);
            i++;
        end
        if (i >= lim) begin
            miscompares++;
            final_report();
        end
    endtask
    // Period of flag events, clearing between them
    task automatic frame_gap(output longint g);
        longint t0;
        bus(1'b1, lcdd_pkg::ADR_STATUS, 8'h01);
        wait_irq(2000);
        t0 = $time;
        bus(1'b1, lcdd_pkg::ADR_STATUS, 8'h01);
        wait_irq(2000);
        g = $time - t0;
    endtask

    // Read data checked against the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) chk(48'h1, 48'h0);
            else chk({16'h0, rdat}, {40'h0, exp_q.pop_front()});
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({44'h0, bp_oe}, 48'h0);
        chk({7'h0, fp_oe}, 48'h0);
        rd(lcdd_pkg::ADR_CONTROL_ZERO, lcdd_pkg::RST_CONTROL_ZERO);
        for (k = 0; k < 6; k++) rd(lcdd_pkg::ADR_FP_ENABLE_0 + {k[5:0], 2'b00}, 8'h00);
        for (k = 0; k < 11; k++) begin
            v = 8'($random(seed));
            bus(1'b1, {k[5:0], 2'b00}, v);
            rd({k[5:0], 2'b00}, v);
        end
        bus(1'b1, 8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        // A write with lane 0 off must leave the register alone
        sel_n = 4'hE;
        bus(1'b1, 8'h28, ~v);
        sel_n = 4'hF;
        rd(8'h28, v);
        // Every supply source code, random pump bits
        for (k = 0; k < 8; k++) begin
            v = {6'($random(seed)), k[1:0]};
            bus(1'b1, lcdd_pkg::ADR_SUPPLY_CONTROL, v);
            chk(pump, v[7]);
            chk(trip, v[6]);
            chk(buf_on, !v[2]);
            chk(ext_ok, v[1:0] == 2'h2);
        end
        bus(1'b1, lcdd_pkg::ADR_CLOCK_SELECT, 8'h80);
        bus(1'b1, lcdd_pkg::ADR_CONTROL_ONE, 8'h80);
        for (k = 0; k < 6; k++) bus(1'b1, lcdd_pkg::ADR_FP_ENABLE_0 + {k[5:0], 2'b00},
            (k < 4) ? 8'hFF : 8'h00);
        bus(1'b1, lcdd_pkg::ADR_CONTROL_ZERO, 8'h83);
        repeat (2) @(posedge clk_i);
        chk({44'h0, bp_oe}, 48'hF);
        chk({7'h0, fp_oe}, 48'hFFFFFFFF);
        chk({42'h0, n_fp}, 48'd32);
        wait_m <= 1'b1;
        stop_m <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({44'h0, bp_oe}, 48'hF);
        chk({7'h0, fp_oe}, 48'hFFFFFFFF);
        frame_gap(g_norm);
        chk(48'(g_norm), 48'd3200);
        rd(lcdd_pkg::ADR_STATUS, 8'h01);
        chk(irq, 1'b1);
        // Blink all at rate 0 toggles on every frame; segment mode keeps the phase
        bus(1'b1, lcdd_pkg::ADR_BLINK_CONTROL, 8'h00);
        bus(1'b1, lcdd_pkg::ADR_BLINK_CONTROL, 8'h88);
        frame_gap(g_lp);
        v = {7'h0, blank};
        bus(1'b1, lcdd_pkg::ADR_STATUS, 8'h01);
        wait_irq(2000);
        chk(blank, !v[0]);
        chk(bseg, 1'b0);
        bus(1'b1, lcdd_pkg::ADR_BLINK_CONTROL, 8'h80);
        chk(blank, 1'b0);
        chk(bseg, !v[0]);
        bus(1'b1, lcdd_pkg::ADR_CONTROL_ZERO, 8'h87);
        frame_gap(g_lp);
        chk(48'(g_norm), 48'(2 * g_lp));
        bus(1'b1, lcdd_pkg::ADR_CONTROL_ZERO, 8'h83);
        bus(1'b1, lcdd_pkg::ADR_CLOCK_SELECT, 8'h81);
        frame_gap(g_adj);
        chk(48'(g_adj), 48'(2 * g_norm));
        // Reference source: no ticks, no frames
        bus(1'b1, lcdd_pkg::ADR_CLOCK_SELECT, 8'h00);
        bus(1'b1, lcdd_pkg::ADR_STATUS, 8'h01);
        chk(irq, 1'b0);
        repeat (100) @(posedge clk_i);
        chk(irq, 1'b0);
        tick_en <= 1'b1;
        wait_irq(1000);
        chk(irq, 1'b1);
        // Reset in mid-run while the panel is driven
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({44'h0, bp_oe}, 48'h0);
        chk({7'h0, fp_oe}, 48'h0);
        rd(lcdd_pkg::ADR_CONTROL_ZERO, lcdd_pkg::RST_CONTROL_ZERO);
        rd(lcdd_pkg::ADR_FP_ENABLE_0, 8'h00);
        final_report();
    end
endmodule // tb_top
`default_nettype wire

//--- verilog/lcdd_frame_timer.sv
`default_nettype none
module lcdd_frame_timer (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // External reference, one-cycle tick per reference edge
    input  wire logic ext_ref_tick_i,
    // Timing link to the controller
    lcdd_tmg_if.tmr   tmg
);
    logic       in_tick;
    logic [5:0] pre_q;
    logic [3:0] d16_q;
    logic       pre_wrap;
    logic [10:0] phase_len;
    logic [10:0] ph_q;
    logic [1:0]  bp_q;
    logic        half_q;
    logic        pol_q;
    logic        pass_end;
    logic        ph_last;

    ////////////////////////////////////////////////////////////////////////
    // Clock source and prescaler
    assign in_tick  = tmg.src_sel ? 1'b1 : ext_ref_tick_i; // RULE1
    assign pre_wrap = in_tick && (pre_q >= tmg.clk_adj); // A lowered adjust must not strand it
    assign tmg.base_tick = pre_wrap && (!tmg.prescale_by_sixteen || d16_q == lcdd_pkg::PRESCALE_BY_SIXTEEN_LAST); // RULE2

    always_ff @(posedge clk_i) begin
        if (rst_i || !tmg.run) begin
            pre_q <= 6'h00;
            d16_q <= 4'h0;
        end else if (in_tick) begin
            pre_q <= pre_wrap ? 6'h00 : pre_q + 6'h01; // RULE2
            if (pre_wrap && tmg.prescale_by_sixteen) begin
                d16_q <= d16_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Backplane phases; low-power waveform halves each phase and runs two passes
    assign phase_len = (lcdd_pkg::PHASE_BASE_TICKS << tmg.frame_rate) >> tmg.low_power_waveform; // RULE15
    // Compare with >= so a shorter phase set mid-count cannot run the counter round its range
    assign ph_last   = ph_q >= phase_len - 11'h001;
    assign pass_end  = tmg.base_tick && ph_last && (bp_q == tmg.duty);
    // Every pass is a frame, or a sub-frame in low-power mode; stale half_q must not mask it
    assign tmg.irq_evt   = pass_end; // RULE12
    assign tmg.frame_evt = pass_end && (half_q || !tmg.low_power_waveform);
    assign tmg.bp_idx    = bp_q;
    assign tmg.polarity  = pol_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !tmg.run) begin
            ph_q   <= 11'h000;
            bp_q   <= 2'h0;
            half_q <= 1'b0;
            pol_q  <= 1'b0;
        end else if (tmg.base_tick) begin
            if (ph_last) begin
                ph_q <= 11'h000;
                bp_q <= (bp_q == tmg.duty) ? 2'h0 : bp_q + 2'h1; // RULE9
                if (pass_end) begin
                    half_q <= tmg.low_power_waveform ? !half_q : 1'b0; // RULE15
                    pol_q  <= !pol_q; // Alternate drive sign to keep DC off the glass
                end
            end else begin
                ph_q <= ph_q + 11'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_EXT_SOURCE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (!tmg.src_sel && !ext_ref_tick_i) |-> !tmg.base_tick)
        else $error("base tick without external reference tick");
    AST_NO_PRESCALE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        (tmg.run && $past(tmg.run) && tmg.src_sel && !tmg.prescale_by_sixteen && tmg.clk_adj == 6'h00)
        |-> tmg.base_tick)
        else $error("undivided bus clock did not tick every cycle");
    AST_FRAME_IS_SUB: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
        tmg.frame_evt |-> tmg.irq_evt)
        else $error("frame event without interrupt event");
endmodule // lcdd_frame_timer
`default_nettype wire

//--- verilog/lcdd_pkg.sv
`default_nettype none
package lcdd_pkg;
    // Register byte addresses on the Wishbone slave
    localparam logic [7:0] ADR_CLOCK_SELECT   = 8'h00;
    localparam logic [7:0] ADR_SUPPLY_CONTROL = 8'h04;
    localparam logic [7:0] ADR_CONTROL_ONE    = 8'h08;
    localparam logic [7:0] ADR_CONTROL_ZERO   = 8'h0C;
    localparam logic [7:0] ADR_BLINK_CONTROL  = 8'h10;
    localparam logic [7:0] ADR_FP_ENABLE_0    = 8'h14;
    localparam logic [7:0] ADR_STATUS         = 8'h2C;
    localparam int         NUM_FP_REGS        = 6;

    // Clock select fields
    localparam int CLK_SOURCE_BIT = 7;
    localparam int CLK_PRESCALE_BY_SIXTEEN_BIT  = 6;
    localparam int CLK_ADJ_MSB    = 5;
    // Supply control fields
    localparam int SUP_PUMP_ON_BIT = 7;
    localparam int SUP_TRIPLER_BIT = 6;
    localparam int SUP_HDRV_BIT    = 5;
    localparam int SUP_CPADJ_LSB   = 3;
    localparam int SUP_BYPASS_BIT  = 2;
    localparam int SUP_SOURCE_LSB  = 0;
    localparam logic [1:0] SUPPLY_EXTERNAL = 2'h2;
    // Control one fields
    localparam int CR1_IRQ_EN_BIT = 7;
    localparam int CR1_WAIT_BIT   = 1;
    localparam int CR1_STOP_BIT   = 0;
    // Control zero fields
    localparam int CR0_ENABLE_BIT = 7;
    localparam int CR0_FRAME_RATE_SELECT_LSB   = 3;
    localparam int CR0_LOW_POWER_WAVEFORM_BIT = 2;
    localparam int CR0_DUTY_LSB   = 0;
    localparam logic [1:0] DUTY_QUARTER = 2'h3;
    // Blink control fields
    localparam int BLK_ENABLE_BIT = 7;
    localparam int BLK_ALL_BIT    = 3;
    localparam int BLK_RATE_LSB   = 0;
    // Status fields
    localparam int STS_FLAG_BIT   = 0;

    // Reset values
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_CONTROL_ZERO = 8'h03;

    // Frame timing: one backplane phase lasts PHASE_BASE_TICKS << frame_rate_select, halved with the low-power waveform
    localparam logic [10:0] PHASE_BASE_TICKS = 11'h008;
    localparam logic [3:0]  PRESCALE_BY_SIXTEEN_LAST       = 4'hF;
endpackage
`default_nettype wire

//--- verilog/lcdd_segment_ctrl.sv
// Contract
// [RULE1] Clock source bit 0 selects external reference, 1 selects bus clock.
// [RULE2] Input clock divided by clock adjust field and optional divide-by-sixteen.
// [RULE3] Charge pump enable bit at 1 turns the pump on.
// [RULE4] Pump multiplier bit: 0 doubler, 1 tripler.
// [RULE5] Bypass bit 0 buffered supply path, 1 unbuffered.
// [RULE6] Supply field 10 expects external power on the panel supply pin.
// [RULE7] Wait-mode disable bit 0 keeps the panel driven during wait.
// [RULE8] Deep-stop disable bit 0 keeps the panel driven during deep stop.
// [RULE9] Duty field 11 drives four backplanes at quarter duty.
// [RULE10] Blink scope bit 0 blinks selected segments, 1 blinks all.
// [RULE11] Six frontplane enable registers; only enabled frontplanes get a waveform.
// [RULE12] Frame or sub-frame event sets flag; writing 1 clears it.
// [RULE13] Interrupt request asserts while flag and interrupt enable are both set.
// [RULE14] Reset clears driver enable and frontplane enables, duty quarter, bias third; the code has no bias field.
// [RULE15] Low-power waveform splits each frame into two equal sub-frames.
// [RULE16] All configuration fields read back the last value written.
`default_nettype none
module lcdd_segment_ctrl #(
    parameter int NUM_FP = 41
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Clock reference and low-power modes
    input  wire logic              ext_ref_tick_i,
    input  wire logic              wait_mode_i,
    input  wire logic              deep_stop_mode_i,
    // Analog supply control
    output logic                   charge_pump_on_o,
    output logic                   pump_tripler_o,
    output logic                   high_drive_buffer_o,
    output logic      [1:0]        pump_clock_adjust_o,
    output logic                   buffer_on_o,
    output logic      [1:0]        supply_source_select_o,
    output logic                   ext_supply_expected_o,
    // Glass drive
    output logic      [NUM_FP-1:0] fp_o,
    output logic      [NUM_FP-1:0] fp_oe_o,
    output logic      [3:0]        bp_o,
    output logic      [3:0]        bp_oe_o,
    output logic                   blank_all_o,
    output logic                   blink_segments_o,
    // Interrupt
    output logic                   lcd_irq_o
);
    logic [7:0] clks_q;
    logic [7:0] supply_q;
    logic [7:0] cr1_q;
    logic [7:0] cr0_q;
    logic [7:0] bctl_q;
    logic [7:0] fpen_q [lcdd_pkg::NUM_FP_REGS];
    logic       flag_q;
    logic       ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [7:0]  blink_cnt_q;
    logic        blink_off_q;
    logic [NUM_FP-1:0] fp_q;
    logic [NUM_FP-1:0] fp_oe_q;
    logic [3:0]  bp_q;
    logic [3:0]  bp_oe_q;

    lcdd_tmg_if tmg ();

    // Byte offset of frontplane enable register n
    function automatic logic [7:0] fp_adr(input int n);
        fp_adr = lcdd_pkg::ADR_FP_ENABLE_0 + 8'(4 * n);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode: write commits on the edge where the master sees ack
    wire req      = wb_cyc_i && wb_stb_i;
    wire wr_lane0 = ack_q && req && wb_we_i && wb_sel_i[0];
    wire wr_clks  = wr_lane0 && (wb_adr_i == lcdd_pkg::ADR_CLOCK_SELECT);
    wire wr_sup   = wr_lane0 && (wb_adr_i == lcdd_pkg::ADR_SUPPLY_CONTROL);
    wire wr_cr1   = wr_lane0 && (wb_adr_i == lcdd_pkg::ADR_CONTROL_ONE);
    wire wr_cr0   = wr_lane0 && (wb_adr_i == lcdd_pkg::ADR_CONTROL_ZERO);
    wire wr_bctl  = wr_lane0 && (wb_adr_i == lcdd_pkg::ADR_BLINK_CONTROL);
    wire wr_sts   = wr_lane0 && (wb_adr_i == lcdd_pkg::ADR_STATUS);
    wire flag_clr = wr_sts && wb_dat_i[lcdd_pkg::STS_FLAG_BIT];

    // Read mux; unmapped addresses read zero and still get ack
    always_comb begin
        rdat_d = 32'h0000_0000;
        if (wb_adr_i == lcdd_pkg::ADR_CLOCK_SELECT) begin
            rdat_d[7:0] = clks_q; // RULE16
        end else if (wb_adr_i == lcdd_pkg::ADR_SUPPLY_CONTROL) begin
            rdat_d[7:0] = supply_q;
        end else if (wb_adr_i == lcdd_pkg::ADR_CONTROL_ONE) begin
            rdat_d[7:0] = cr1_q;
        end else if (wb_adr_i == lcdd_pkg::ADR_CONTROL_ZERO) begin
            rdat_d[7:0] = cr0_q;
        end else if (wb_adr_i == lcdd_pkg::ADR_BLINK_CONTROL) begin
            rdat_d[7:0] = bctl_q;
        end else if (wb_adr_i == lcdd_pkg::ADR_STATUS) begin
            rdat_d[lcdd_pkg::STS_FLAG_BIT] = flag_q;
        end else begin
            for (int n = 0; n < lcdd_pkg::NUM_FP_REGS; n++) begin
                if (wb_adr_i == fp_adr(n)) begin
                    rdat_d[7:0] = fpen_q[n]; // RULE11
                end
            end
        end
    end

    // Ack one cycle after the request, dropped in the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req && !ack_q;
            rdat_q <= rdat_d;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clks_q   <= lcdd_pkg::RST_ZERO;
            supply_q <= lcdd_pkg::RST_ZERO;
            cr1_q    <= lcdd_pkg::RST_ZERO;
            cr0_q    <= lcdd_pkg::RST_CONTROL_ZERO; // RULE14
            bctl_q   <= lcdd_pkg::RST_ZERO;
        end else begin
            if (wr_clks) clks_q <= wb_dat_i[7:0]; // RULE16
            if (wr_sup)  supply_q <= wb_dat_i[7:0];
            if (wr_cr1)  cr1_q <= wb_dat_i[7:0];
            if (wr_cr0)  cr0_q <= wb_dat_i[7:0];
            if (wr_bctl) bctl_q <= wb_dat_i[7:0];
        end
    end

    // Frontplane enables, one register per group of eight
    for (genvar g = 0; g < lcdd_pkg::NUM_FP_REGS; g++) begin : g_fpen
        wire wr_fp = wr_lane0 && (wb_adr_i == fp_adr(g));
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                fpen_q[g] <= lcdd_pkg::RST_ZERO; // RULE14
            end else if (wr_fp) begin
                fpen_q[g] <= wb_dat_i[7:0]; // RULE11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Supply control straight from the register
    assign charge_pump_on_o       = supply_q[lcdd_pkg::SUP_PUMP_ON_BIT]; // RULE3
    assign pump_tripler_o         = supply_q[lcdd_pkg::SUP_TRIPLER_BIT]; // RULE4
    assign high_drive_buffer_o    = supply_q[lcdd_pkg::SUP_HDRV_BIT];
    assign pump_clock_adjust_o    = supply_q[lcdd_pkg::SUP_CPADJ_LSB +: 2];
    assign buffer_on_o            = !supply_q[lcdd_pkg::SUP_BYPASS_BIT]; // RULE5
    assign supply_source_select_o = supply_q[lcdd_pkg::SUP_SOURCE_LSB +: 2];
    assign ext_supply_expected_o  = (supply_source_select_o == lcdd_pkg::SUPPLY_EXTERNAL); // RULE6

    ////////////////////////////////////////////////////////////////////////
    // Timer hookup; the timer halts while the panel is not being driven
    wire driver_en = cr0_q[lcdd_pkg::CR0_ENABLE_BIT];
    wire wait_off  = wait_mode_i && cr1_q[lcdd_pkg::CR1_WAIT_BIT]; // RULE7
    wire stop_off  = deep_stop_mode_i && cr1_q[lcdd_pkg::CR1_STOP_BIT]; // RULE8
    wire driving   = driver_en && !wait_off && !stop_off;

    assign tmg.src_sel    = clks_q[lcdd_pkg::CLK_SOURCE_BIT]; // RULE1
    assign tmg.prescale_by_sixteen      = clks_q[lcdd_pkg::CLK_PRESCALE_BY_SIXTEEN_BIT]; // RULE2
    assign tmg.clk_adj    = clks_q[lcdd_pkg::CLK_ADJ_MSB:0];
    assign tmg.frame_rate = cr0_q[lcdd_pkg::CR0_FRAME_RATE_SELECT_LSB +: 3];
    assign tmg.low_power_waveform     = cr0_q[lcdd_pkg::CR0_LOW_POWER_WAVEFORM_BIT]; // RULE15
    assign tmg.duty       = cr0_q[lcdd_pkg::CR0_DUTY_LSB +: 2]; // RULE9
    assign tmg.run        = driving;

    lcdd_frame_timer u_timer (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .ext_ref_tick_i (ext_ref_tick_i),
        .tmg            (tmg.tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame flag: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (tmg.irq_evt) begin
            flag_q <= 1'b1; // RULE12
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end
    assign lcd_irq_o = flag_q && cr1_q[lcdd_pkg::CR1_IRQ_EN_BIT]; // RULE13

    ////////////////////////////////////////////////////////////////////////
    // Blink timing: toggles after 2**rate frames
    wire [2:0] blink_rate = bctl_q[lcdd_pkg::BLK_RATE_LSB +: 3];
    wire blink_en  = bctl_q[lcdd_pkg::BLK_ENABLE_BIT];
    wire blink_all = bctl_q[lcdd_pkg::BLK_ALL_BIT];
    wire blink_top = (blink_cnt_q == 8'((9'h001 << blink_rate) - 9'h001));

    always_ff @(posedge clk_i) begin
        if (rst_i || !blink_en) begin
            blink_cnt_q <= 8'h00;
            blink_off_q <= 1'b0;
        end else if (tmg.frame_evt) begin
            blink_cnt_q <= blink_top ? 8'h00 : blink_cnt_q + 8'h01;
            if (blink_top) begin
                blink_off_q <= !blink_off_q;
            end
        end
    end
    assign blank_all_o      = blink_en && blink_all && blink_off_q; // RULE10
    assign blink_segments_o = blink_en && !blink_all && blink_off_q; // RULE10

    ////////////////////////////////////////////////////////////////////////
    // Glass pins; segment data lives elsewhere, so frontplanes carry the on level, opposite the selected backplane
    wire [47:0] fp_en_flat = {fpen_q[5], fpen_q[4], fpen_q[3], fpen_q[2], fpen_q[1], fpen_q[0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fp_q    <= '0;
            fp_oe_q <= '0;
            bp_q    <= 4'h0;
            bp_oe_q <= 4'h0;
        end else begin
            fp_q    <= {NUM_FP{tmg.polarity}};
            fp_oe_q <= driving ? fp_en_flat[NUM_FP-1:0] : '0; // RULE11
            bp_q    <= (4'h1 << tmg.bp_idx) ^ {4'(tmg.polarity ? 4'hF : 4'h0)};
            // Unused backplanes float so they can serve as frontplanes
            bp_oe_q <= driving ? 4'((5'h02 << tmg.duty) - 5'h01) : 4'h0; // RULE9
        end
    end
    assign fp_o    = fp_q;
    assign fp_oe_o = fp_oe_q;
    assign bp_o    = bp_q;
    assign bp_oe_o = bp_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wr_sup;
        wr_sup;
    endsequence

    AST_PUMP_ON: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        s_wr_sup ##0 wb_dat_i[7] |=> charge_pump_on_o)
        else $error("pump not on after enable write");
    AST_PUMP_MODE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        s_wr_sup |=> pump_tripler_o == $past(wb_dat_i[6]))
        else $error("pump multiplier mismatch");
    AST_BYPASS: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        s_wr_sup |=> buffer_on_o == !$past(wb_dat_i[2]))
        else $error("buffer path mismatch");
    AST_EXT_SUPPLY: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        s_wr_sup ##0 (wb_dat_i[1:0] == 2'h2) |=> ext_supply_expected_o)
        else $error("external supply not flagged");
    AST_WAIT_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        (driver_en && wait_mode_i && !cr1_q[1] && !stop_off) |=> bp_oe_o != 4'h0)
        else $error("panel dropped in wait mode");
    AST_STOP_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        (driver_en && deep_stop_mode_i && !cr1_q[0] && !wait_off) |=> bp_oe_o != 4'h0)
        else $error("panel dropped in deep stop");
    AST_QUARTER: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        (driving && tmg.duty == 2'h3) |=> bp_oe_o == 4'hF)
        else $error("quarter duty not using four backplanes");
    AST_BLINK_ALL: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        blank_all_o |-> !blink_segments_o && bctl_q[3])
        else $error("blink scope mismatch");
    AST_FP_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        driving && !$past(rst_i) |=> fp_oe_o == $past(fp_en_flat[NUM_FP-1:0]))
        else $error("frontplane enable not applied");
    AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        tmg.irq_evt |=> flag_q)
        else $error("frame flag not set on event");
    AST_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        flag_q && !flag_clr |=> flag_q)
        else $error("frame flag lost without clear");
    AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        (tmg.irq_evt && cr1_q[lcdd_pkg::CR1_IRQ_EN_BIT] && !wr_cr1) |=> lcd_irq_o)
        else $error("interrupt request mismatch");
    AST_RESET: assert property (@(posedge clk_i) // RULE14
        rst_i |=> !driver_en && tmg.duty == 2'h3 && fp_oe_o == '0 && bp_oe_o == 4'h0)
        else $error("reset defaults wrong");
    AST_READBACK: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
        wr_clks |=> clks_q == $past(wb_dat_i[7:0]) ##1 1'b1)
        else $error("clock select not stored");
endmodule // lcdd_segment_ctrl
`default_nettype wire

//--- verilog/lcdd_tmg_if.sv
`default_nettype none
interface lcdd_tmg_if;
    logic       src_sel;
    logic       prescale_by_sixteen;
    logic [5:0] clk_adj;
    logic [2:0] frame_rate;
    logic       low_power_waveform;
    logic [1:0] duty;
    logic       run;
    logic       base_tick;
    logic       frame_evt;
    logic       irq_evt;
    logic [1:0] bp_idx;
    logic       polarity;

    modport ctl (output src_sel, prescale_by_sixteen, clk_adj, frame_rate, low_power_waveform, duty, run,
                 input base_tick, frame_evt, irq_evt, bp_idx, polarity);
    modport tmr (input src_sel, prescale_by_sixteen, clk_adj, frame_rate, low_power_waveform, duty, run,
                 output base_tick, frame_evt, irq_evt, bp_idx, polarity);
endinterface
`default_nettype wire
